// file: rtl/sleep_wake_and_brownout_ctrl.sv
// Notes on behaviour
// - Power-down is entered only by the sleep instruction strobe.
// - Sleep entry clears watchdog; it keeps counting if enabled in sleep.
// - Sleep entry clears power-down flag and sets time-out flag.
// - Processor clock enable is off while asleep.
// - Low-frequency oscillator domain stays enabled in sleep.
// - Timer1 runs in sleep on low-freq, pin or secondary oscillator.
// - Converter keeps running in sleep on its dedicated oscillator.
// - Port drive state is frozen during sleep.
// - Sleep leaves resets unchanged, except watchdog timeout, which wakes and resumes.
// - Wake on pin, brown-out, power-on, watchdog, external or sleep-capable interrupt.
// - Pin, brown-out and power-on wake reset fully; others resume.
// - Next instruction is prefetched while sleep executes.
// - Individual enable gates interrupt wake; global enable does not.
// - After interrupt wake, run next instruction, then vector if globally enabled.
// - Watchdog is cleared on every wake-up.
// - Software brown-out enable acts only when config field is 01.
// - Fast-start forces band-gap on only when config is 10 or 01.
// - Read-only ready bit shows brown-out circuit active.
//
// The AHB-Lite register port and the address map were chosen for this implementation.
`timescale 1ns/1ps
`include "sleep_ctrl_map.svh"

module sleep_wake_and_brownout_ctrl
	import sleep_ctrl_pkg::*;
#(
	parameter int NIRQ  = 8,
	parameter int NPORT = 8
) (
	input  wire logic             clk,
	input  wire logic             rstn,
	// AHB-Lite slave
	input  wire logic             hsel,
	input  wire logic [11:0]      haddr,
	input  wire logic [1:0]       htrans,
	input  wire logic             hwrite,
	input  wire logic [2:0]       hsize,
	input  wire logic [31:0]      hwdata,
	input  wire logic             hready,
	output logic [31:0]           hrdata,
	output logic                  hreadyout,
	output logic                  hresp,
	// Core side
	input  wire logic             sleepInstr,
	input  wire logic             globalIrqEnable,
	output logic                  cpuClkEn,
	output logic                  prefetchNext,
	output logic                  execNextStrobe,
	output logic                  vectorIrq,
	output logic                  powerDownFlag,
	output logic                  timeOutFlag,
	// Interrupt and watchdog
	input  wire logic [NIRQ-1:0]  irqFlag,
	input  wire logic [NIRQ-1:0]  irqEnable,
	input  wire logic [NIRQ-1:0]  irqRunsInSleep,
	input  wire logic             wdtTimeout,
	input  wire logic             wdtSleepEn,
	output logic                  wdtClear,
	output logic                  wdtRunEn,
	// Reset sources
	input  wire logic             extResetPin,
	input  wire logic             extResetPinEn,
	input  wire logic             powerOnReset,
	input  wire logic             brownoutDetect,
	input  wire logic [1:0]       configBrownoutMode,
	output logic                  fullReset,
	output logic                  brownoutActive,
	output logic                  bandgapForceOn,
	// Peripheral clock gates
	output logic                  lowFreqOscEn,
	output logic                  timer1ClkEn,
	output logic                  adcClkEn,
	// Ports
	input  wire logic [NPORT-1:0] portOutIn,
	input  wire logic [NPORT-1:0] portOeIn,
	output logic [NPORT-1:0]      portOut,
	output logic [NPORT-1:0]      portOe
);
	if (NIRQ < 1 || NIRQ > 32 || NPORT < 1 || NPORT > 32) begin : g_check_params
		$error("NIRQ and NPORT must be 1..32");
	end

	// -----------------------------------------------------------------
	// Decoding helpers
	// -----------------------------------------------------------------
	function automatic logic bor_active(input logic [1:0] m, input logic sw,
	                                    input logic asleep);
		unique case (m)
			`CFG_OFF:     return 1'b0;
			`CFG_SOFT:    return sw;
			`CFG_NOSLEEP: return !asleep;
			`CFG_ON:      return 1'b1;
		endcase
	endfunction : bor_active

	// -----------------------------------------------------------------
	// Registers and wires
	// -----------------------------------------------------------------
	sleep_state_type state_q;
	logic            swBorEn_q;
	logic            fastStart_q;
	logic [1:0]      t1Src_q;
	logic            adcDedOsc_q;
	logic            irqWake;
	logic            wdtWake;
	logic            resetWake;
	logic            borNow;
	logic            wakeIrqSeen_q;
	logic            apWrite_q;
	logic            addrPhase;
	logic [11:0]     apAddr_q;

	wake_source_mux #(.NIRQ(NIRQ)) wake_source_mux_inst (
		.irqFlag        (irqFlag),
		.irqEnable      (irqEnable),
		.irqRunsInSleep (irqRunsInSleep),
		.wdtTimeout     (wdtTimeout),
		.wdtSleepEn     (wdtSleepEn),
		.irqWake        (irqWake),
		.wdtWake        (wdtWake)
	);

	// Brown-out is only a wake source while the circuit is armed
	assign borNow    = bor_active(configBrownoutMode, swBorEn_q, state_q == ASLEEP_ST);
	assign resetWake = (extResetPin & extResetPinEn) | powerOnReset
	                 | (brownoutDetect & borNow);

	// -----------------------------------------------------------------
	// AHB-Lite slave: zero wait state, always OKAY
	// -----------------------------------------------------------------
	// Accepted address phase; only whole-word transfers are served
	assign addrPhase = hready && hsel && (htrans == `HTRANS_NONSEQ) && (hsize == `HSIZE_WORD);
	// Write address held for the data phase
	always_ff @(posedge clk) begin
		if (!rstn) begin
			apWrite_q <= 1'b0;
			apAddr_q  <= '0;
		end else if (hready) begin
			apWrite_q <= addrPhase && hwrite;
			apAddr_q  <= haddr;
		end
	end

	// Writable control bits; unmapped writes are dropped
	always_ff @(posedge clk) begin
		if (!rstn) begin
			swBorEn_q   <= `BORCTL_SWEN_RST;
			fastStart_q <= `BORCTL_FAST_RST;
			t1Src_q     <= `PERIPH_T1SRC_RST;
			adcDedOsc_q <= `PERIPH_ADCOSC_RST;
		end else if (apWrite_q) begin
			if (apAddr_q == `BORCTL_ADDR) begin
				swBorEn_q   <= hwdata[`BORCTL_SWEN_BIT];
				fastStart_q <= hwdata[`BORCTL_FAST_BIT];
			end else if (apAddr_q == `PERIPH_ADDR) begin
				t1Src_q     <= hwdata[`PERIPH_T1SRC_MSB:`PERIPH_T1SRC_LSB];
				adcDedOsc_q <= hwdata[`PERIPH_ADCOSC_BIT];
			end
		end
	end

	// Read data loaded on the address edge so it stands through the data phase
	always_ff @(posedge clk) begin
		if (!rstn) begin
			hrdata <= 32'h0000_0000;
		end else if (addrPhase && !hwrite) begin
			hrdata <= 32'h0000_0000;
			unique case (haddr)
				`BORCTL_ADDR: begin
					hrdata[`BORCTL_SWEN_BIT] <= swBorEn_q;
					hrdata[`BORCTL_FAST_BIT] <= fastStart_q;
					hrdata[`BORCTL_RDY_BIT]  <= brownoutActive;
				end
				`CPUSTAT_ADDR: begin
					hrdata[`STAT_PD_BIT]      <= powerDownFlag;
					hrdata[`STAT_TO_BIT]      <= timeOutFlag;
					hrdata[`STAT_ASLEEP_BIT]  <= (state_q == ASLEEP_ST);
					hrdata[`STAT_WAKEIRQ_BIT] <= wakeIrqSeen_q;
				end
				`PERIPH_ADDR: begin
					hrdata[`PERIPH_T1SRC_MSB:`PERIPH_T1SRC_LSB] <= t1Src_q;
					hrdata[`PERIPH_ADCOSC_BIT]                 <= adcDedOsc_q;
				end
				default: hrdata <= 32'h0000_0000;
			endcase
		end
	end

	// Never stalls and never errors, in reset or out of it
	always_ff @(posedge clk) begin
		hreadyout <= 1'b1;
		hresp     <= 1'b0;
	end

	// -----------------------------------------------------------------
	// Sleep sequencer
	// -----------------------------------------------------------------
	// Entry only by the sleep strobe; WAKE_ST gives the clock a cycle before fetch
	always_ff @(posedge clk) begin
		if (!rstn) begin
			state_q <= RUN_ST;
		end else begin
			unique case (state_q)
				RUN_ST:    if (sleepInstr) state_q <= ASLEEP_ST;
				ASLEEP_ST: if (resetWake || irqWake || wdtWake) state_q <= WAKE_ST;
				WAKE_ST:   state_q <= RESUME_ST;
				RESUME_ST: state_q <= RUN_ST;
			endcase
		end
	end

	// Clock gate: off in sleep, back on at wake detection
	always_ff @(posedge clk) begin
		if (!rstn) begin
			cpuClkEn <= 1'b1;
		end else if (state_q == RUN_ST && sleepInstr) begin
			cpuClkEn <= 1'b0;
		end else if (state_q == ASLEEP_ST && (resetWake || irqWake || wdtWake)) begin
			cpuClkEn <= 1'b1;
		end
	end

	// Prefetch strobe, registered one cycle after the sleep instruction
	always_ff @(posedge clk) begin
		if (!rstn) begin
			prefetchNext <= 1'b0;
		end else begin
			prefetchNext <= (state_q == RUN_ST) && sleepInstr;
		end
	end

	// Remember an interrupt-caused resume (reset wake takes priority)
	always_ff @(posedge clk) begin
		if (!rstn) begin
			wakeIrqSeen_q <= 1'b0;
		end else if (state_q == ASLEEP_ST && !resetWake && (irqWake || wdtWake)) begin
			wakeIrqSeen_q <= irqWake;
		end else if (state_q == RUN_ST && sleepInstr) begin
			wakeIrqSeen_q <= 1'b0;
		end
	end

	// Wake outcome: reset-type wakes reset fully, others run next then maybe vector
	always_ff @(posedge clk) begin
		if (!rstn) begin
			fullReset      <= 1'b0;
			execNextStrobe <= 1'b0;
			vectorIrq      <= 1'b0;
		end else begin
			fullReset      <= (state_q == ASLEEP_ST) && resetWake;
			execNextStrobe <= (state_q == WAKE_ST) && !fullReset;
			vectorIrq      <= (state_q == RESUME_ST) && wakeIrqSeen_q
			                  && globalIrqEnable;
		end
	end

	// Watchdog clear on entry and on every wake
	always_ff @(posedge clk) begin
		if (!rstn) begin
			wdtClear <= 1'b0;
		end else begin
			wdtClear <= ((state_q == RUN_ST) && sleepInstr)
			          || (state_q == WAKE_ST);
		end
	end

	// Watchdog keeps running in sleep only if enabled for sleep
	always_ff @(posedge clk) begin
		if (!rstn) begin
			wdtRunEn <= 1'b1;
		end else begin
			wdtRunEn <= (state_q == ASLEEP_ST) ? wdtSleepEn : 1'b1;
		end
	end

	// Status flags; a power-on reset restores both to their idle level
	always_ff @(posedge clk) begin
		if (!rstn) begin
			powerDownFlag <= 1'b1;
			timeOutFlag   <= 1'b1;
		end else if (powerOnReset) begin
			powerDownFlag <= 1'b1;
			timeOutFlag   <= 1'b1;
		end else if (state_q == RUN_ST && sleepInstr) begin
			powerDownFlag <= 1'b0;
			timeOutFlag   <= 1'b1;
		end
	end

	// Brown-out arming and band-gap force
	always_ff @(posedge clk) begin
		if (!rstn) begin
			brownoutActive <= 1'b0;
			bandgapForceOn <= 1'b0;
		end else begin
			brownoutActive <= borNow;
			bandgapForceOn <= fastStart_q && (configBrownoutMode == `CFG_SOFT
			                  || configBrownoutMode == `CFG_NOSLEEP);
		end
	end

	// Peripheral clock gates; low-freq oscillator is never stopped by sleep
	always_ff @(posedge clk) begin
		if (!rstn) begin
			lowFreqOscEn <= 1'b1;
			timer1ClkEn  <= 1'b1;
			adcClkEn     <= 1'b1;
		end else begin
			lowFreqOscEn <= 1'b1;
			timer1ClkEn  <= (state_q != ASLEEP_ST) || (t1Src_q == `T1SRC_LFOSC)
			                || (t1Src_q == `T1SRC_PIN) || (t1Src_q == `T1SRC_SECOSC);
			adcClkEn     <= (state_q != ASLEEP_ST) || adcDedOsc_q;
		end
	end

	// Port drive frozen while asleep
	always_ff @(posedge clk) begin
		if (!rstn) begin
			portOut <= '0;
			portOe  <= '0;
		end else if (state_q != ASLEEP_ST) begin
			portOut <= portOutIn;
			portOe  <= portOeIn;
		end
	end

	// -----------------------------------------------------------------
	// Checks
	// -----------------------------------------------------------------
	a_entry_clkoff: assert property (@(posedge clk) disable iff (!rstn)
		(state_q == RUN_ST && sleepInstr) |=> !cpuClkEn && state_q == ASLEEP_ST)
		else $error("clock not gated on sleep entry");
	a_no_spur_sleep: assert property (@(posedge clk) disable iff (!rstn)
		(state_q == RUN_ST && !sleepInstr) |=> state_q != ASLEEP_ST)
		else $error("sleep without instruction");
	a_entry_flags: assert property (@(posedge clk) disable iff (!rstn)
		(state_q == RUN_ST && sleepInstr && !powerOnReset) |=> !powerDownFlag && timeOutFlag)
		else $error("flags wrong after entry");
	a_wdt_entry: assert property (@(posedge clk) disable iff (!rstn)
		(state_q == RUN_ST && sleepInstr) |=> wdtClear)
		else $error("watchdog not cleared at entry");
	a_wdt_wake: assert property (@(posedge clk) disable iff (!rstn)
		(state_q == ASLEEP_ST && (resetWake || irqWake || wdtWake)) |=> ##1 wdtClear)
		else $error("watchdog not cleared at wake");
	a_wake_clkon: assert property (@(posedge clk) disable iff (!rstn)
		(state_q == ASLEEP_ST && irqWake) |=> cpuClkEn ##1 (execNextStrobe || $past(fullReset)))
		else $error("clock not back before resume");
	a_reset_wake: assert property (@(posedge clk) disable iff (!rstn)
		(state_q == ASLEEP_ST && resetWake) |=> fullReset)
		else $error("reset wake without full reset");
	a_vector_gie: assert property (@(posedge clk) disable iff (!rstn)
		vectorIrq |-> $past(globalIrqEnable) && $past(state_q, 1) == RESUME_ST)
		else $error("vector without global enable");
	a_port_hold: assert property (@(posedge clk) disable iff (!rstn)
		(state_q == ASLEEP_ST && $past(state_q) == ASLEEP_ST) |-> $stable(portOut))
		else $error("port changed in sleep");
	a_bandgap: assert property (@(posedge clk) disable iff (!rstn)
		(configBrownoutMode == `CFG_ON && $past(configBrownoutMode) == `CFG_ON)
		|-> !bandgapForceOn)
		else $error("band-gap forced in wrong mode");
	a_prefetch: assert property (@(posedge clk) disable iff (!rstn)
		(state_q == RUN_ST && sleepInstr) |=> prefetchNext)
		else $error("no prefetch with sleep");
	c_irq_wake: cover property (@(posedge clk) disable iff (!rstn)
		state_q == ASLEEP_ST ##1 state_q == WAKE_ST ##2 vectorIrq);
	c_reset_wake: cover property (@(posedge clk) disable iff (!rstn) fullReset);
	c_wdt_wake: cover property (@(posedge clk) disable iff (!rstn)
		state_q == ASLEEP_ST && wdtWake && !irqWake);
endmodule : sleep_wake_and_brownout_ctrl

// file: rtl/sleep_ctrl_map.svh
`ifndef SLEEP_CTRL_MAP_SVH
`define SLEEP_CTRL_MAP_SVH

// Register byte offsets on the bus
`define BORCTL_ADDR        12'h000
`define CPUSTAT_ADDR       12'h004
`define PERIPH_ADDR        12'h008
// Brown-out control fields
`define BORCTL_SWEN_BIT    7
`define BORCTL_FAST_BIT    6
`define BORCTL_RDY_BIT     0
`define BORCTL_SWEN_RST    1'b1
`define BORCTL_FAST_RST    1'b0
// Status fields
`define STAT_PD_BIT        0
`define STAT_TO_BIT        1
`define STAT_ASLEEP_BIT    2
`define STAT_WAKEIRQ_BIT   3
// Peripheral clock control fields
`define PERIPH_T1SRC_MSB   1
`define PERIPH_T1SRC_LSB   0
`define PERIPH_ADCOSC_BIT  2
`define PERIPH_T1SRC_RST   2'h0
`define PERIPH_ADCOSC_RST  1'h0
// Configuration field codes
`define CFG_OFF            2'h0
`define CFG_SOFT           2'h1
`define CFG_NOSLEEP        2'h2
`define CFG_ON             2'h3
// Peripheral clock source codes
`define T1SRC_LFOSC        2'h1
`define T1SRC_PIN          2'h2
`define T1SRC_SECOSC       2'h3
// AHB codes
`define HTRANS_NONSEQ      2'h2
`define HSIZE_WORD         3'h2

`endif

// file: rtl/sleep_ctrl_pkg.sv
package sleep_ctrl_pkg;
	typedef enum logic [1:0] {
		RUN_ST    = 2'b00,
		ASLEEP_ST = 2'b01,
		WAKE_ST   = 2'b11,
		RESUME_ST = 2'b10
	} sleep_state_type;
endpackage : sleep_ctrl_pkg

// file: rtl/wake_source_mux.sv
`timescale 1ns/1ps
`include "sleep_ctrl_map.svh"

// Qualifies raw wake events; interrupts need their own enable and run-in-sleep bit, not the global enable
module wake_source_mux #(
	parameter int NIRQ = 8
) (
	input  wire logic [NIRQ-1:0] irqFlag,
	input  wire logic [NIRQ-1:0] irqEnable,
	input  wire logic [NIRQ-1:0] irqRunsInSleep,
	input  wire logic            wdtTimeout,
	input  wire logic            wdtSleepEn,
	output logic                 irqWake,
	output logic                 wdtWake
);
	// Global enable deliberately not an input: it must not gate wake
	assign irqWake = |(irqFlag & irqEnable & irqRunsInSleep);
	assign wdtWake = wdtTimeout & wdtSleepEn;
endmodule : wake_source_mux

// file: tb/core_model.sv
`timescale 1ns/1ps

// ----------------------------------------
// Core stand-in
// ----------------------------------------
// Issues the sleep opcode on request and tallies every strobe the controller
// sends back. It does not check timing itself; the bench reads the tally.
module core_model (
	input  wire logic        clk,
	input  wire logic        req,
	input  wire logic        clr,
	input  wire logic        prefetchNext,
	input  wire logic        execNextStrobe,
	input  wire logic        vectorIrq,
	input  wire logic        wdtClear,
	input  wire logic        fullReset,
	output logic             sleepInstr,
	output logic [19:0]      tally
);
	// One-cycle sleep opcode; the slot after it is treated as a no-op
	always_ff @(posedge clk) begin
		sleepInstr <= req;
	end

	// Nibbles: prefetch, execute-next, vector, watchdog clear, full reset
	always_ff @(posedge clk) begin
		if (clr) begin
			tally <= 20'h00000;
		end else begin
			tally <= tally + {3'h0, prefetchNext, 3'h0, execNextStrobe, 3'h0, vectorIrq,
				3'h0, wdtClear, 3'h0, fullReset};
		end
	end
endmodule : core_model

// file: tb/sleep_wake_and_brownout_ctrl_tb.sv
`timescale 1ns/1ps
`include "sleep_ctrl_map.svh"

module sleep_wake_and_brownout_ctrl_tb;
	logic        clk = 1'b0;
	logic        rstn = 1'b0;
	logic        hsel = 1'b0;
	logic [11:0] haddr = 12'h000;
	logic [1:0]  htrans = 2'h0;
	logic        hwrite = 1'b0;
	logic [2:0]  hsize = `HSIZE_WORD;
	logic [31:0] hwdata = 32'h00000000;
	logic        globalIrqEnable = 1'b0;
	logic [7:0]  irqFlag = 8'h00;
	logic [7:0]  irqEnable = 8'h00;
	logic [7:0]  irqRunsInSleep = 8'hFF;
	logic        wdtTimeout = 1'b0;
	logic        wdtSleepEn = 1'b1;
	logic        extResetPin = 1'b0;
	logic        extResetPinEn = 1'b1;
	logic        powerOnReset = 1'b0;
	logic        brownoutDetect = 1'b0;
	logic [1:0]  configBrownoutMode = `CFG_SOFT;
	logic [7:0]  portOutIn = 8'h00;
	logic [7:0]  portOeIn = 8'h00;
	logic        req = 1'b0;
	logic        clr = 1'b1;
	logic [31:0] hrdata;
	logic        hreadyout, hresp, sleepInstr, cpuClkEn, prefetchNext, execNextStrobe;
	logic        vectorIrq, powerDownFlag, timeOutFlag, wdtClear, wdtRunEn, fullReset;
	logic        brownoutActive, bandgapForceOn, lowFreqOscEn, timer1ClkEn, adcClkEn;
	logic [7:0]  portOut, portOe;
	logic [19:0] tally;
	int          errors = 0;
	int          tests_run = 0;

	// 25 MHz clock
	always #20 clk = ~clk;

	sleep_wake_and_brownout_ctrl sleep_wake_and_brownout_ctrl_inst (
		.clk(clk), .rstn(rstn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
		.hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
		.hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .sleepInstr(sleepInstr),
		.globalIrqEnable(globalIrqEnable), .cpuClkEn(cpuClkEn), .prefetchNext(prefetchNext),
		.execNextStrobe(execNextStrobe), .vectorIrq(vectorIrq),
		.powerDownFlag(powerDownFlag), .timeOutFlag(timeOutFlag), .irqFlag(irqFlag),
		.irqEnable(irqEnable), .irqRunsInSleep(irqRunsInSleep), .wdtTimeout(wdtTimeout),
		.wdtSleepEn(wdtSleepEn), .wdtClear(wdtClear), .wdtRunEn(wdtRunEn),
		.extResetPin(extResetPin), .extResetPinEn(extResetPinEn), .powerOnReset(powerOnReset),
		.brownoutDetect(brownoutDetect), .configBrownoutMode(configBrownoutMode),
		.fullReset(fullReset), .brownoutActive(brownoutActive),
		.bandgapForceOn(bandgapForceOn), .lowFreqOscEn(lowFreqOscEn),
		.timer1ClkEn(timer1ClkEn), .adcClkEn(adcClkEn), .portOutIn(portOutIn),
		.portOeIn(portOeIn), .portOut(portOut), .portOe(portOe)
	);

	core_model core_model_inst (
		.clk(clk), .req(req), .clr(clr), .prefetchNext(prefetchNext),
		.execNextStrobe(execNextStrobe), .vectorIrq(vectorIrq), .wdtClear(wdtClear),
		.fullReset(fullReset), .sleepInstr(sleepInstr), .tally(tally)
	);

	// ----------------------------------------
	// Shared tasks
	// ----------------------------------------
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		tests_run++;
		if (seen !== exp) begin
			errors++;
			$display("Error at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask : check

	// Single word transfer; entered just after a rising edge
	task automatic ahb(input logic wr, input logic [11:0] addr, input logic [31:0] wd,
		output logic [31:0] rd);
		hsel   <= 1'b1;
		haddr  <= addr;
		hwrite <= wr;
		htrans <= `HTRANS_NONSEQ;
		@(posedge clk);
		while (hreadyout !== 1'b1) @(posedge clk);
		hsel   <= 1'b0;
		htrans <= 2'h0;
		hwdata <= wd;
		@(posedge clk);
		while (hreadyout !== 1'b1) @(posedge clk);
		rd = hrdata;
	endtask : ahb

	task automatic wr(input logic [11:0] addr, input logic [31:0] wd);
		logic [31:0] rd;
		ahb(1'b1, addr, wd, rd);
	endtask : wr

	task automatic rdchk(input logic [11:0] addr, input logic [31:0] exp);
		logic [31:0] rd;
		ahb(1'b0, addr, 32'h00000000, rd);
		check(rd, exp);
	endtask : rdchk

	// Sleep, prove the block holds, then wake from source 0 irq, 1 watchdog,
	// 2 pin, 3 brown-out or 4 power-on; the last three must reset fully
	task automatic sleep_cycle(input int src, input logic global_irq_enable, input logic [31:0] per);
		int   n;
		logic e;
		logic v;
		logic f;
		e = (src < 2);
		v = (src == 0) && global_irq_enable;
		f = (src >= 2);
		wr(`PERIPH_ADDR, per);
		globalIrqEnable <= global_irq_enable;
		wdtSleepEn      <= (src != 0);
		portOutIn       <= 8'hA5;
		portOeIn        <= 8'h0F;
		clr             <= 1'b1;
		repeat (2) @(posedge clk);
		clr <= 1'b0;
		req <= 1'b1;
		@(posedge clk);
		req <= 1'b0;
		repeat (3) @(posedge clk);
		portOutIn <= 8'h5A;
		portOeIn  <= 8'hF0;
		check(cpuClkEn, 32'h0);
		check(powerDownFlag, 32'h0);
		check(timeOutFlag, 32'h1);
		check(wdtRunEn, src != 0);
		check(lowFreqOscEn, 32'h1);
		check(timer1ClkEn, per[1:0] != 2'h0);
		check(adcClkEn, per[2]);
		rdchk(`CPUSTAT_ADDR, 32'h6);
		check(portOut, 32'hA5);
		check(portOe, 32'h0F);
		// Neither a flagged interrupt without its enable nor a disabled pin may wake
		irqFlag       <= 8'h01;
		extResetPinEn <= 1'b0;
		extResetPin   <= 1'b1;
		repeat (4) @(posedge clk);
		check(cpuClkEn, 32'h0);
		extResetPinEn <= 1'b1;
		extResetPin   <= (src == 2);
		if (src == 0) irqEnable <= 8'h01;
		if (src == 1) wdtTimeout <= 1'b1;
		if (src == 3) brownoutDetect <= 1'b1;
		if (src == 4) powerOnReset <= 1'b1;
		n = 0;
		while (cpuClkEn !== 1'b1 && n < 10) begin
			@(posedge clk);
			n++;
		end
		check(cpuClkEn, 32'h1);
		irqFlag     <= 8'h00;
		irqEnable   <= 8'h00;
		wdtTimeout  <= 1'b0;
		extResetPin    <= 1'b0;
		brownoutDetect <= 1'b0;
		powerOnReset   <= 1'b0;
		repeat (6) @(posedge clk);
		check(tally, {12'h000, 4'h1, 3'h0, e, 3'h0, v, 4'h2, 3'h0, f});
		if (src != 2) check(portOut, 32'h5A);
		rdchk(`CPUSTAT_ADDR, {28'h0, (src == 0), 2'h1, (src == 4)});
	endtask : sleep_cycle

	// ----------------------------------------
	// Scenarios
	// ----------------------------------------
	task automatic scen_reset_regs();
		rdchk(`BORCTL_ADDR, 32'h81);
		rdchk(`CPUSTAT_ADDR, 32'h3);
		wr(12'hFFC, 32'hFFFFFFFF);
		check(hresp, 32'h0);
		rdchk(12'hFFC, 32'h0);
		rdchk(`BORCTL_ADDR, 32'h81);
	endtask : scen_reset_regs

	// Every config code with the two control bits both clear and both set
	task automatic scen_bor_modes();
		logic [2:0] k;
		logic       act;
		for (int i = 0; i < 8; i++) begin
			k = i[2:0];
			act = (k[2:1] == 2'h3) || (k[2:1] == 2'h2) || (k[2:1] == 2'h1 && k[0]);
			configBrownoutMode <= k[2:1];
			wr(`BORCTL_ADDR, k[0] ? 32'hFF : 32'h00);
			repeat (3) @(posedge clk);
			check(brownoutActive, act);
			check(bandgapForceOn, k[0] && (k[2:1] == 2'h1 || k[2:1] == 2'h2));
			rdchk(`BORCTL_ADDR, {24'h0, k[0], k[0], 5'h0, act});
		end
		configBrownoutMode <= `CFG_SOFT;
	endtask : scen_bor_modes

	task automatic scen_irq_wake();
		sleep_cycle(0, 1'b1, 32'h5);
	endtask : scen_irq_wake

	task automatic scen_irq_no_global();
		sleep_cycle(0, 1'b0, 32'h0);
	endtask : scen_irq_no_global

	task automatic scen_wdt_wake();
		sleep_cycle(1, 1'b1, 32'h3);
	endtask : scen_wdt_wake

	task automatic scen_pin_wake();
		sleep_cycle(2, 1'b1, 32'h2);
	endtask : scen_pin_wake

	task automatic scen_bor_wake();
		sleep_cycle(3, 1'b1, 32'h1);
	endtask : scen_bor_wake

	task automatic scen_por_wake();
		sleep_cycle(4, 1'b0, 32'h4);
	endtask : scen_por_wake

	task automatic conclude();
		$display("Comparisons %0d, mismatches %0d", tests_run, errors);
		if (errors == 0 && tests_run > 0) begin
			$display("TB: PASS");
		end else begin
			$display("TB: FAIL");
		end
		$finish;
	endtask : conclude

	// Main sequence
	initial begin
		repeat (20) @(posedge clk);
		rstn <= 1'b1;
		@(posedge clk);
		scen_reset_regs();
		scen_bor_modes();
		scen_irq_wake();
		scen_irq_no_global();
		scen_wdt_wake();
		scen_pin_wake();
		scen_bor_wake();
		scen_por_wake();
		conclude();
	end

	// Hang guard, far beyond the few hundred cycles the sequence needs
	initial begin
		repeat (20000) @(posedge clk);
		errors++;
		conclude();
	end
endmodule : sleep_wake_and_brownout_ctrl_tb
